// [src/bmu_pkg.sv]
`default_nettype none
package bmu_pkg;

  // ****************************************************************
  // datapath and bus widths
  // ****************************************************************
  localparam int          XLEN        = 32;
  localparam int          AW          = 8;
  localparam int          CNTW        = 6;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0]  OFF_SRC_A   = 8'h00;
  localparam logic [7:0]  OFF_SRC_B   = 8'h04;
  localparam logic [7:0]  OFF_CTRL    = 8'h08;
  localparam logic [7:0]  OFF_RES_LO  = 8'h0c;
  localparam logic [7:0]  OFF_RES_HI  = 8'h10;
  localparam logic [7:0]  OFF_STATUS  = 8'h14;
  localparam logic [7:0]  OFF_FEAT_L7 = 8'h18;
  localparam logic [7:0]  OFF_FEAT_EX = 8'h1c;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int          CTRL_GO_BIT     = 8;
  localparam int          ST_DONE_BIT     = 0;
  localparam int          ST_ILLEGAL_BIT  = 1;
  localparam int          ST_FLAGS_LSB    = 4;
  localparam int          FEAT_GRP1_BIT   = 3;
  localparam int          FEAT_GRP2_BIT   = 8;
  localparam int          FEAT_LZC_BIT    = 5;
  localparam int          START_LSB       = 0;
  localparam int          LEN_LSB         = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [3:0]  RST_OP      = 4'h0;

  // ****************************************************************
  // operations and flags
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_AND_NOT, OP_FIELD_EXTRACT, OP_ISOLATE_LOWEST_ONE, OP_MASK_BELOW_LOWEST_ONE,
    OP_CLEAR_LOWEST_ONE, OP_ZERO_HIGH, OP_LEADING_ZERO_COUNT, OP_TRAILING_ZERO_COUNT,
    OP_FLAGLESS_MULTIPLY, OP_BIT_DEPOSIT, OP_BIT_GATHER, OP_FLAGLESS_ROTATE,
    OP_FLAGLESS_ARITH_SHIFT, OP_FLAGLESS_LEFT_SHIFT, OP_FLAGLESS_RIGHT_SHIFT
  } bmu_op_e;

  typedef struct packed {
    logic overflow;
    logic sign;
    logic zero;
    logic carry;
  } bmu_flags_s;

  localparam bmu_flags_s  RST_FLAGS   = '{default: 1'b0};

endpackage
`default_nettype wire

// [src/bmu_unit.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - and with inverted second operand
// - isolate lowest set bit only
// - ones up to lowest set bit
// - clear lowest set bit, keep others
// - zero bits from given index upward
// - count zeros above highest one
// - count zeros below lowest one
// - unsigned product, flags untouched
// - deposit low source bits at mask ones
// - gather masked bits into low bits
// - rotate right, flags untouched
// - only general operand registers used
// - group one feature at bit three
// - group two feature at bit eight
// - leading zero feature at bit five
module bmu_unit
  import bmu_pkg::*;
#(
  parameter bit GROUP1_EN = 1'b1,
  parameter bit GROUP2_EN = 1'b1,
  parameter bit LZC_EN    = 1'b1
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               result_valid
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [XLEN-1:0]   src_a_r;
  logic [XLEN-1:0]   src_b_r;
  logic [3:0]        op_r;
  logic              go_r;
  logic [XLEN-1:0]   res_lo_r;
  logic [XLEN-1:0]   res_hi_r;
  logic              done_r;
  logic              illegal_r;
  bmu_flags_s        flags_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;

  logic              wr_en;
  logic              rd_setup;
  logic [2*XLEN-1:0] res_nxt;
  bmu_flags_s        flags_nxt;
  logic              flags_upd;
  logic              legal;
  logic              carry;
  logic [31:0]       feat_l7;
  logic [31:0]       feat_ex;
  logic [31:0]       rd_word;
  logic              rd_hit;

  // writes land on the access edge, reads are staged at setup so the
  // access cycle can answer with zero wait from a flop
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign pready   = 1'b1;
  assign prdata   = prdata_r;
  assign pslverr  = pslverr_r;
  assign result_valid = done_r;

  // ****************************************************************
  // feature bits
  // ****************************************************************
  always_comb begin
    feat_l7 = RST_WORD;
    feat_ex = RST_WORD;
    feat_l7[FEAT_GRP1_BIT] = GROUP1_EN;
    feat_l7[FEAT_GRP2_BIT] = GROUP2_EN;
    feat_ex[FEAT_LZC_BIT]  = LZC_EN;
  end

  // ****************************************************************
  // operand registers
  // ****************************************************************
  // operands live only in these general words, no wide vector state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_a_r <= RST_WORD;
      src_b_r <= RST_WORD;
    end else if (wr_en && paddr == OFF_SRC_A) begin
      src_a_r <= pwdata;
    end else if (wr_en && paddr == OFF_SRC_B) begin
      src_b_r <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= RST_OP;
      go_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      if (wr_en && paddr == OFF_CTRL) begin
        op_r <= pwdata[3:0];
        go_r <= pwdata[CTRL_GO_BIT];
      end
    end
  end

  // ****************************************************************
  // operation datapath
  // ****************************************************************
  always_comb begin
    logic [63:0]     fmask;
    logic [XLEN-1:0] lo;
    logic [CNTW-1:0] cnt;
    logic [CNTW-1:0] k;
    logic            found;
    logic [7:0]      start;
    logic [7:0]      len;
    logic [4:0]      sh;
    fmask     = 64'h0;
    lo        = RST_WORD;
    cnt       = '0;
    k         = '0;
    found     = 1'b0;
    start     = src_b_r[START_LSB +: 8];
    len       = src_b_r[LEN_LSB +: 8];
    sh        = src_b_r[4:0];
    res_nxt   = '0;
    carry     = 1'b0;
    flags_upd = 1'b1;
    legal     = GROUP1_EN;
    case (op_r)
      OP_AND_NOT: begin
        lo = src_a_r & ~src_b_r;
      end
      OP_FIELD_EXTRACT: begin
        fmask = (64'h1 << len) - 64'h1;
        if (start < 8'h20) begin
          lo = (src_a_r >> start) & fmask[XLEN-1:0];
        end
      end
      OP_ISOLATE_LOWEST_ONE: begin
        lo    = src_a_r & (~src_a_r + 32'h1);
        carry = |src_a_r;
      end
      OP_MASK_BELOW_LOWEST_ONE: begin
        lo    = src_a_r ^ (src_a_r - 32'h1);
        carry = ~|src_a_r;
      end
      OP_CLEAR_LOWEST_ONE: begin
        lo    = src_a_r & (src_a_r - 32'h1);
        carry = ~|src_a_r;
      end
      OP_ZERO_HIGH: begin
        legal = GROUP2_EN;
        fmask = (64'h1 << src_b_r[7:0]) - 64'h1;
        lo    = src_a_r & fmask[XLEN-1:0];
        carry = src_b_r[7:0] > 8'h1f;
      end
      OP_LEADING_ZERO_COUNT: begin
        legal = LZC_EN;
        for (int i = XLEN - 1; i >= 0; i--) begin
          if (!found) begin
            if (src_a_r[i]) begin
              found = 1'b1;
            end else begin
              cnt = cnt + 6'h01;
            end
          end
        end
        lo    = {26'h0, cnt};
        carry = ~|src_a_r;
      end
      OP_TRAILING_ZERO_COUNT: begin
        for (int i = 0; i < XLEN; i++) begin
          if (!found) begin
            if (src_a_r[i]) begin
              found = 1'b1;
            end else begin
              cnt = cnt + 6'h01;
            end
          end
        end
        lo    = {26'h0, cnt};
        carry = ~|src_a_r;
      end
      OP_FLAGLESS_MULTIPLY: begin
        legal     = GROUP2_EN;
        flags_upd = 1'b0;
        res_nxt   = {32'h0, src_a_r} * {32'h0, src_b_r};
      end
      OP_BIT_DEPOSIT: begin
        legal     = GROUP2_EN;
        flags_upd = 1'b0;
        for (int i = 0; i < XLEN; i++) begin
          if (src_b_r[i]) begin
            lo[i] = src_a_r[k[4:0]];
            k     = k + 6'h01;
          end
        end
      end
      OP_BIT_GATHER: begin
        legal     = GROUP2_EN;
        flags_upd = 1'b0;
        for (int i = 0; i < XLEN; i++) begin
          if (src_b_r[i]) begin
            lo[k[4:0]] = src_a_r[i];
            k          = k + 6'h01;
          end
        end
      end
      OP_FLAGLESS_ROTATE: begin
        legal     = GROUP2_EN;
        flags_upd = 1'b0;
        fmask     = {src_a_r, src_a_r} >> sh;
        lo        = fmask[XLEN-1:0];
      end
      OP_FLAGLESS_ARITH_SHIFT: begin
        legal     = GROUP2_EN;
        flags_upd = 1'b0;
        lo        = $signed(src_a_r) >>> sh;
      end
      OP_FLAGLESS_LEFT_SHIFT: begin
        legal     = GROUP2_EN;
        flags_upd = 1'b0;
        lo        = src_a_r << sh;
      end
      OP_FLAGLESS_RIGHT_SHIFT: begin
        legal     = GROUP2_EN;
        flags_upd = 1'b0;
        lo        = src_a_r >> sh;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
    if (op_r != OP_FLAGLESS_MULTIPLY) begin
      res_nxt = {32'h0, lo};
    end
    // an absent or unknown operation yields zero and leaves flags alone
    if (!legal) begin
      res_nxt   = '0;
      flags_upd = 1'b0;
    end
    flags_nxt.overflow = 1'b0;
    flags_nxt.sign     = lo[XLEN-1];
    flags_nxt.zero     = ~|lo;
    flags_nxt.carry    = carry;
  end

  // ****************************************************************
  // results, flags, status
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_lo_r  <= RST_WORD;
      res_hi_r  <= RST_WORD;
      illegal_r <= 1'b0;
    end else if (go_r) begin
      res_lo_r  <= res_nxt[XLEN-1:0];
      res_hi_r  <= res_nxt[2*XLEN-1:XLEN];
      illegal_r <= ~legal;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= RST_FLAGS;
    end else if (go_r && flags_upd) begin
      flags_r <= flags_nxt;
    end
  end

  // completion beats the clear that a new control write makes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (go_r) begin
      done_r <= 1'b1;
    end else if (wr_en && paddr == OFF_CTRL) begin
      done_r <= 1'b0;
    end
  end

  // ****************************************************************
  // register read decode
  // ****************************************************************
  always_comb begin
    rd_word = RST_WORD;
    rd_hit  = 1'b1;
    if (paddr == OFF_SRC_A) begin
      rd_word = src_a_r;
    end else if (paddr == OFF_SRC_B) begin
      rd_word = src_b_r;
    end else if (paddr == OFF_CTRL) begin
      rd_word = {28'h0, op_r};
    end else if (paddr == OFF_RES_LO) begin
      rd_word = res_lo_r;
    end else if (paddr == OFF_RES_HI) begin
      rd_word = res_hi_r;
    end else if (paddr == OFF_STATUS) begin
      rd_word[ST_DONE_BIT]        = done_r;
      rd_word[ST_ILLEGAL_BIT]     = illegal_r;
      rd_word[ST_FLAGS_LSB +: 4]  = flags_r;
    end else if (paddr == OFF_FEAT_L7) begin
      rd_word = feat_l7;
    end else if (paddr == OFF_FEAT_EX) begin
      rd_word = feat_ex;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= RST_WORD;
      pslverr_r <= 1'b0;
    end else if (rd_setup) begin
      prdata_r  <= pwrite ? RST_WORD : rd_word;
      pslverr_r <= ~rd_hit;
    end
  end

endmodule
`default_nettype wire

// [test/bmu_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ********************************
// core side bus master
// ********************************
module bmu_core_model
  import bmu_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          pready,
  input  wire logic          pslverr,
  input  wire logic [31:0]   prdata,
  output logic               psel,
  output logic               penable,
  output logic               pwrite,
  output logic [AW-1:0]      paddr,
  output logic [31:0]        pwdata
);
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= '0;
    pwdata <= '0;
  end
  // released address and data lines show the inverse so stale values never pass
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                      output logic [32:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [test/bmu_unit_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// ********************************
// bench top
// ********************************
module bmu_unit_bench
  import bmu_pkg::*;
;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel, penable, pwrite, pready, pslverr, result_valid;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata;
  int            n_fail = 0;
  int            n_tests = 0;
  always #2.5 pclk = ~pclk;
  bmu_unit i_bmu_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .result_valid(result_valid));
  bmu_core_model i_bmu_core_model (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [32:0] r;
    i_bmu_core_model.xfer(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [AW-1:0] a, input logic [32:0] exp);
    logic [32:0] r;
    i_bmu_core_model.xfer(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  // waits on done after the edge settles, never a fixed latency
  task automatic t_op(input bmu_op_e op, input logic [31:0] a, b, exp);
    int n;
    wr(OFF_SRC_A, a);
    wr(OFF_SRC_B, b);
    wr(OFF_CTRL, (32'h1 << CTRL_GO_BIT) | 32'(op));
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (result_valid !== 1'b1 && n < 20);
    chk({32'h0, result_valid}, 33'h1);
    rd_chk(OFF_RES_LO, {1'b0, exp});
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFF_SRC_A, {1'b0, RST_WORD});
    rd_chk(OFF_STATUS, 33'h0);
    rd_chk(OFF_FEAT_L7, 33'h108);
    rd_chk(OFF_FEAT_EX, 33'h20);
    rd_chk(8'h20, 33'h1_0000_0000);
    $display("register test done");
    t_op(OP_AND_NOT, 32'hf0f0_1234, 32'hff00_0204, 32'h00f0_1030);
    t_op(OP_FIELD_EXTRACT, 32'hb6a0, 32'h0804, 32'h6a);
    t_op(OP_ISOLATE_LOWEST_ONE, 32'hb6a0, 32'h0, 32'h20);
    t_op(OP_MASK_BELOW_LOWEST_ONE, 32'hb6a0, 32'h0, 32'h3f);
    t_op(OP_CLEAR_LOWEST_ONE, 32'hb6a0, 32'h0, 32'hb680);
    t_op(OP_ZERO_HIGH, 32'hffff_ffff, 32'hc, 32'hfff);
    t_op(OP_ZERO_HIGH, 32'hffff_ffff, 32'h0, 32'h0);
    t_op(OP_LEADING_ZERO_COUNT, 32'hb6a0, 32'h0, 32'h10);
    t_op(OP_TRAILING_ZERO_COUNT, 32'hb6a0, 32'h0, 32'h5);
    t_op(OP_TRAILING_ZERO_COUNT, 32'h0, 32'h0, 32'h20);
    rd_chk(OFF_STATUS, 33'h11);
    $display("group one test done");
    t_op(OP_FLAGLESS_MULTIPLY, 32'hffff_ffff, 32'hffff_ffff, 32'h1);
    rd_chk(OFF_RES_HI, 33'hffff_fffe);
    rd_chk(OFF_STATUS, 33'h11);
    t_op(OP_BIT_DEPOSIT, 32'h5, 32'hf0f0, 32'h50);
    t_op(OP_BIT_GATHER, 32'ha5c3, 32'hf0f0, 32'hac);
    t_op(OP_FLAGLESS_ROTATE, 32'h1, 32'h1, 32'h8000_0000);
    rd_chk(OFF_STATUS, 33'h11);
    t_op(OP_FLAGLESS_ARITH_SHIFT, 32'h8000_0000, 32'h24, 32'hf800_0000);
    t_op(OP_FLAGLESS_LEFT_SHIFT, 32'h1, 32'h24, 32'h10);
    t_op(OP_FLAGLESS_RIGHT_SHIFT, 32'h8000_0000, 32'h24, 32'h0800_0000);
    rd_chk(OFF_STATUS, 33'h11);
    $display("group two test done");
    t_op(bmu_op_e'(4'hf), 32'h1234, 32'h0, 32'h0);
    rd_chk(OFF_STATUS, 33'h13);
    rd_chk(OFF_CTRL, 33'hf);
    $display("refusal test done");
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    end_sim();
  end
endmodule
bind bmu_unit bmu_unit_chk #(.GROUP1_EN(GROUP1_EN), .GROUP2_EN(GROUP2_EN), .LZC_EN(LZC_EN))
  i_bmu_unit_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .result_valid(result_valid));
`default_nettype wire

// [test/bmu_unit_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ********************************
// bus and feature checks
// ********************************
module bmu_unit_chk
  import bmu_pkg::*;
#(
  parameter bit GROUP1_EN = 1'b1,
  parameter bit GROUP2_EN = 1'b1,
  parameter bit LZC_EN    = 1'b1
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [31:0]   prdata,
  input  wire logic          pready,
  input  wire logic          pslverr,
  input  wire logic          result_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic rda = acc && !pwrite;
  sequence go_wr;
    acc && pwrite && paddr == OFF_CTRL && pwdata[CTRL_GO_BIT];
  endsequence
  // done drops for one cycle, so a stale result is never taken as new
  sequence done_seq;
    !result_valid ##1 result_valid;
  endsequence
  AST_READY: assert property (acc |-> pready)
    else $error("no zero wait answer");
  AST_FEAT_ONE: assert property (rda && paddr == OFF_FEAT_L7 |-> prdata[FEAT_GRP1_BIT] == GROUP1_EN)
    else $error("group one bit wrong");
  AST_FEAT_TWO: assert property (rda && paddr == OFF_FEAT_L7 |-> prdata[FEAT_GRP2_BIT] == GROUP2_EN)
    else $error("group two bit wrong");
  AST_FEAT_LZC: assert property (rda && paddr == OFF_FEAT_EX |-> prdata[FEAT_LZC_BIT] == LZC_EN)
    else $error("leading count bit wrong");
  AST_UNMAP: assert property (acc && paddr > OFF_FEAT_EX |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (acc && paddr <= OFF_FEAT_EX && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  AST_HOLD: assert property (acc ##1 !psel |-> $stable(prdata))
    else $error("read data not held");
  AST_GO_RD: assert property (rda && paddr == OFF_CTRL |-> !prdata[CTRL_GO_BIT])
    else $error("go bit reads back");
  AST_DONE: assert property (go_wr |=> done_seq)
    else $error("done timing wrong");
endmodule
`default_nettype wire
